// ---- rtl/call_clear_defs.vh ----
/*
 * Constants for the call and clear execution block: operation codes,
 * widths and cycle counts.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef CALL_CLEAR_DEFS_VH
`define CALL_CLEAR_DEFS_VH

`define PC_W 13
`define DADDR_W 8
`define OP_W 3
`define OP_NONE 3'h0
`define OP_CALL 3'h1
`define OP_ZERO_STORE 3'h2
`define OP_BIT_CLEAR 3'h3
`define OP_WD_SINGLE 3'h4
`define OP_WD_FIRST 3'h5
`define OP_WD_SECOND 3'h6
`define CALL_CYCLES 2
`define RET_INC 13'h0001
`define ZERO_BYTE 8'h00
`define PAIR_NONE 2'h0
`define PAIR_FIRST 2'h1
`define PAIR_SECOND 2'h2

`endif

// ---- rtl/call_clear_exec.v ----
/*
 * Execution of subroutine call, byte clear, bit clear and watchdog
 * clear operations inside the core.
 * Assumes the fetch stage presents one operation per cycle while
 * ready_out is high; data memory and stack sit outside.
 */
`timescale 1ns/1ps
`include "call_clear_defs.vh"

module call_clear_exec (
    // Clock and reset
    input wire core_clk_in,
    input wire rst_n_in,
    // Operation request
    input wire op_valid_in,
    input wire [`OP_W-1:0] op_code_in,
    input wire [`PC_W-1:0] call_addr_in,
    input wire [`DADDR_W-1:0] mem_addr_in,
    input wire [2:0] bit_sel_in,
    input wire [7:0] mem_rdata_in,
    input wire [`PC_W-1:0] pc_in,
    output wire ready_out,
    // Data memory write
    output wire mem_we_out,
    output wire [`DADDR_W-1:0] mem_waddr_out,
    output wire [7:0] mem_wdata_out,
    // Stack push and program counter load
    output wire stack_push_out,
    output wire [`PC_W-1:0] stack_data_out,
    output wire pc_load_out,
    output wire [`PC_W-1:0] pc_next_out,
    // Watchdog
    output wire watchdog_counter_clear_out,
    output wire timeout_flag_clear_out,
    output wire powerdown_flag_clear_out
);
    localparam ST_IDLE = 1'b0;
    localparam ST_CALL2 = 1'b1;

    // Sequencer state
    reg state_q;
    reg state_d;
    reg [`PC_W-1:0] target_q;
    reg [`PC_W-1:0] target_d;
    // Data memory write registers
    reg mem_we_q;
    reg mem_we_d;
    reg [`DADDR_W-1:0] mem_waddr_q;
    reg [`DADDR_W-1:0] mem_waddr_d;
    reg [7:0] mem_wdata_q;
    reg [7:0] mem_wdata_d;
    // Stack and program counter registers
    reg stack_push_q;
    reg stack_push_d;
    reg [`PC_W-1:0] stack_data_q;
    reg [`PC_W-1:0] stack_data_d;
    reg pc_load_q;
    reg pc_load_d;
    reg [`PC_W-1:0] pc_next_q;
    reg [`PC_W-1:0] pc_next_d;
    // Watchdog clear registers
    reg wd_count_clear_q;
    reg wd_timeout_clear_q;
    reg wd_powerdown_clear_q;
    reg wd_clear_d;
    // Decoded operations
    wire take;
    wire do_call;
    wire do_zero_store;
    wire do_bit_clear;
    wire do_wd_single;
    wire do_wd_first;
    wire do_wd_second;
    wire pair_clear;

    function [7:0] clear_bit;
        input [7:0] val;
        input [2:0] sel;
        begin
            clear_bit = val & ~(8'h01 << sel);
        end
    endfunction

    // Taken operation matches one code
    function op_hit;
        input taken;
        input [`OP_W-1:0] code;
        input [`OP_W-1:0] want;
        begin
            op_hit = taken && (code == want);
        end
    endfunction

    // Return address pushed by a call
    function [`PC_W-1:0] return_addr;
        input [`PC_W-1:0] pc;
        begin
            return_addr = pc + `RET_INC;
        end
    endfunction

    // Second call cycle stalls fetch
    assign ready_out = (state_q == ST_IDLE);
    assign take = op_valid_in && ready_out;
    assign do_call = op_hit(take, op_code_in, `OP_CALL);
    assign do_zero_store = op_hit(take, op_code_in, `OP_ZERO_STORE);
    assign do_bit_clear = op_hit(take, op_code_in, `OP_BIT_CLEAR);
    assign do_wd_single = op_hit(take, op_code_in, `OP_WD_SINGLE);
    assign do_wd_first = op_hit(take, op_code_in, `OP_WD_FIRST);
    assign do_wd_second = op_hit(take, op_code_in, `OP_WD_SECOND);

    preclear_pair u_pair (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .first_half_in(do_wd_first),
        .second_half_in(do_wd_second),
        .pair_clear_out(pair_clear)
    );

    // Next state and next outputs
    always @* begin
        state_d = state_q;
        target_d = target_q;
        mem_we_d = 1'b0;
        mem_waddr_d = mem_waddr_q;
        mem_wdata_d = mem_wdata_q;
        stack_push_d = 1'b0;
        stack_data_d = stack_data_q;
        pc_load_d = 1'b0;
        pc_next_d = pc_next_q;
        wd_clear_d = do_wd_single || pair_clear;
        case (state_q)
            ST_IDLE: begin
                if (do_call) begin
                    // No flag outputs touched by a call
                    stack_push_d = 1'b1;
                    stack_data_d = return_addr(pc_in);
                    target_d = call_addr_in;
                    state_d = ST_CALL2;
                end else if (do_zero_store) begin
                    mem_we_d = 1'b1;
                    mem_waddr_d = mem_addr_in;
                    mem_wdata_d = `ZERO_BYTE;
                end else if (do_bit_clear) begin
                    mem_we_d = 1'b1;
                    mem_waddr_d = mem_addr_in;
                    mem_wdata_d = clear_bit(mem_rdata_in,
                        bit_sel_in);
                end
            end
            ST_CALL2: begin
                pc_load_d = 1'b1;
                pc_next_d = target_q;
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            state_q <= ST_IDLE;
            target_q <= {`PC_W{1'b0}};
        end else begin
            state_q <= state_d;
            target_q <= target_d;
        end
    end

    // Data memory write registers
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            mem_we_q <= 1'b0;
            mem_waddr_q <= {`DADDR_W{1'b0}};
            mem_wdata_q <= `ZERO_BYTE;
        end else begin
            mem_we_q <= mem_we_d;
            mem_waddr_q <= mem_waddr_d;
            mem_wdata_q <= mem_wdata_d;
        end
    end

    // Stack and program counter registers
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            stack_push_q <= 1'b0;
            stack_data_q <= {`PC_W{1'b0}};
            pc_load_q <= 1'b0;
            pc_next_q <= {`PC_W{1'b0}};
        end else begin
            stack_push_q <= stack_push_d;
            stack_data_q <= stack_data_d;
            pc_load_q <= pc_load_d;
            pc_next_q <= pc_next_d;
        end
    end

    // Watchdog clear registers
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            wd_count_clear_q <= 1'b0;
            wd_timeout_clear_q <= 1'b0;
            wd_powerdown_clear_q <= 1'b0;
        end else begin
            // All three cleared together
            wd_count_clear_q <= wd_clear_d;
            wd_timeout_clear_q <= wd_clear_d;
            wd_powerdown_clear_q <= wd_clear_d;
        end
    end

    // Outputs straight from registers
    assign mem_we_out = mem_we_q;
    assign mem_waddr_out = mem_waddr_q;
    assign mem_wdata_out = mem_wdata_q;
    assign stack_push_out = stack_push_q;
    assign stack_data_out = stack_data_q;
    assign pc_load_out = pc_load_q;
    assign pc_next_out = pc_next_q;
    assign watchdog_counter_clear_out = wd_count_clear_q;
    assign timeout_flag_clear_out = wd_timeout_clear_q;
    assign powerdown_flag_clear_out = wd_powerdown_clear_q;
endmodule

// ---- rtl/preclear_pair.v ----
/*
 * Tracks which half of the watchdog pre-clear pair ran last and
 * grants a clear only when the halves alternate.
 * Assumes single-cycle strobes, one per executed instruction.
 */
`timescale 1ns/1ps
`include "call_clear_defs.vh"

module preclear_pair (
    // Clock and reset
    input wire core_clk_in,
    input wire rst_n_in,
    // Half strobes
    input wire first_half_in,
    input wire second_half_in,
    // Grant
    output wire pair_clear_out
);
    reg [1:0] last_q;
    reg [1:0] last_d;
    reg grant;

    always @* begin
        last_d = last_q;
        grant = 1'b0;
        if (first_half_in) begin
            // Repeat of the same half does nothing
            grant = (last_q == `PAIR_SECOND);
            last_d = `PAIR_FIRST;
        end else if (second_half_in) begin
            grant = (last_q == `PAIR_FIRST);
            last_d = `PAIR_SECOND;
        end
    end

    assign pair_clear_out = grant;

    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            last_q <= `PAIR_NONE;
        end else begin
            last_q <= last_d;
        end
    end
endmodule

// ---- verif/call_and_clear_instruction_exec_bench.sv ----
/* Random bench with a reference model for call and clear execution.
   Assumes the design header is on the include path. */
`timescale 1ns/1ps
module call_and_clear_instruction_exec_bench;
reg core_clk_in=0,rst_n_in=0,op_valid_in=0,tk,ew,wd,bz;
reg [2:0] op_code_in=0,bit_sel_in=0;
reg [12:0] call_addr_in=0,pc_in=0,cq;
reg [7:0] mem_addr_in=0,mem_rdata_in=0;
wire ready_out,mem_we_out,stack_push_out,pc_load_out;
wire watchdog_counter_clear_out,timeout_flag_clear_out;
wire powerdown_flag_clear_out;
wire [7:0] mem_waddr_out,mem_wdata_out;
wire [12:0] stack_data_out,pc_next_out;
reg [48:0] ex,act;
reg [31:0] r=32'h0000_97df;
reg [1:0] lh;
integer fail_count=0,n_checks=0;
call_clear_exec dut (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .op_valid_in(op_valid_in),
    .op_code_in(op_code_in),
    .call_addr_in(call_addr_in),
    .mem_addr_in(mem_addr_in),
    .bit_sel_in(bit_sel_in),
    .mem_rdata_in(mem_rdata_in),
    .pc_in(pc_in),
    .ready_out(ready_out),
    .mem_we_out(mem_we_out),
    .mem_waddr_out(mem_waddr_out),
    .mem_wdata_out(mem_wdata_out),
    .stack_push_out(stack_push_out),
    .stack_data_out(stack_data_out),
    .pc_load_out(pc_load_out),
    .pc_next_out(pc_next_out),
    .watchdog_counter_clear_out(watchdog_counter_clear_out),
    .timeout_flag_clear_out(timeout_flag_clear_out),
    .powerdown_flag_clear_out(powerdown_flag_clear_out)
);
function [31:0] nx(input [31:0] v);
    nx={v[30:0],v[31]^v[21]^v[1]^v[0]};
endfunction
initial forever #50 core_clk_in=~core_clk_in;
// Model, then random drive
always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
        bz=0;
        lh=0;
        ex={1'b1,48'h0};
    end else begin
        tk=op_valid_in&&!bz;
        ew=tk&&op_code_in>1&&op_code_in<4;
        wd=tk&&(op_code_in==4||op_code_in==5&&lh==2||op_code_in==6&&lh==1);
        ex={!(tk&&op_code_in==1),ew,ew?mem_addr_in:8'h0,
            ew&&op_code_in==3?mem_rdata_in&~(8'h1<<bit_sel_in):8'h0,
            tk&&op_code_in==1,tk&&op_code_in==1?pc_in+13'h1:13'h0,
            bz,bz?cq:13'h0,{3{wd}}};
        if (tk&&op_code_in>4&&op_code_in<7) lh=op_code_in[1:0];
        bz=tk&&op_code_in==1;
        cq=call_addr_in;
    end
    r=nx(r);
    op_valid_in<=r[0]|r[1];
    op_code_in<=r[4:2];
    bit_sel_in<=r[7:5];
    mem_addr_in<=r[15:8];
    mem_rdata_in<=r[23:16];
    call_addr_in<=r[31:19];
    pc_in<=r[12:0];
end
always @(negedge core_clk_in) if (rst_n_in) begin
    act={ready_out,mem_we_out,mem_we_out?mem_waddr_out:8'h0,
        mem_we_out?mem_wdata_out:8'h0,stack_push_out,
        stack_push_out?stack_data_out:13'h0,pc_load_out,
        pc_load_out?pc_next_out:13'h0,watchdog_counter_clear_out,
        timeout_flag_clear_out,powerdown_flag_clear_out};
    chk(49'h1_0000_0000_0000);
    chk(49'h0_FFFF_8000_0000);
    chk(49'h0_0000_7FFE_0000);
    chk(49'h0_0000_0001_FFF8);
    chk(49'h0_0000_0000_0007);
end
// Compares one masked field of the result vector
task chk(input [48:0] m);
    begin
        n_checks=n_checks+1;
        if ((act&m)!==(ex&m)) begin
            fail_count=fail_count+1;
            $display("Error %0t got %h exp %h",$time,act&m,ex&m);
        end
    end
endtask
task give_verdict;
    if (fail_count==0&&n_checks>0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask
initial begin
    repeat (6) @(posedge core_clk_in);
    rst_n_in<=1;
    repeat (1500) @(posedge core_clk_in);
    rst_n_in<=0;
    repeat (2) @(posedge core_clk_in);
    rst_n_in<=1;
    repeat (1500) @(posedge core_clk_in);
    give_verdict;
end
initial begin
    #400000;
    fail_count=fail_count+1;
    give_verdict;
end
endmodule

// ---- verif/call_clear_monitor.sv ----
/* Assertions on the call and clear execution ports.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module call_clear_monitor (
    // Clock and reset
    input wire core_clk_in,
    input wire rst_n_in,
    // Operation request
    input wire op_valid_in,
    input wire [2:0] op_code_in,
    input wire [12:0] call_addr_in,
    input wire [7:0] mem_addr_in,
    input wire [2:0] bit_sel_in,
    input wire [7:0] mem_rdata_in,
    input wire [12:0] pc_in,
    input wire ready_out,
    // Results
    input wire mem_we_out,
    input wire [7:0] mem_waddr_out,
    input wire [7:0] mem_wdata_out,
    input wire stack_push_out,
    input wire [12:0] stack_data_out,
    input wire pc_load_out,
    input wire [12:0] pc_next_out,
    input wire watchdog_counter_clear_out,
    input wire timeout_flag_clear_out,
    input wire powerdown_flag_clear_out
);
wire t=op_valid_in&&ready_out;
wire [2:0] c=op_code_in;
wire w=watchdog_counter_clear_out;
reg [1:0] lq;
// Last pre-clear half taken: 1 first, 2 second
always @(posedge core_clk_in) begin
    if (!rst_n_in) lq<=2'h0;
    else if (t&&(c==3'h5||c==3'h6)) lq<=c[1:0];
end
default clocking @(posedge core_clk_in); endclocking
default disable iff (!rst_n_in);
a_call_push: assert property (t&&c==1 |=> stack_push_out&&
    stack_data_out==$past(pc_in)+13'h1) else $error("push");
a_call_load: assert property (t&&c==1 |=> !ready_out ##1
    pc_load_out&&ready_out&&pc_next_out==$past(call_addr_in,2))
    else $error("load");
a_zero_store: assert property (t&&c==2 |=>
    mem_we_out&&mem_wdata_out==8'h0) else $error("zero");
a_bit_clear: assert property (t&&c==3 |=> mem_we_out&&
    mem_wdata_out==($past(mem_rdata_in)&~(8'h1<<$past(bit_sel_in))))
    else $error("bit");
a_wd_single: assert property (t&&c==4 |=> w) else $error("wd");
a_flags_together: assert property (w==timeout_flag_clear_out&&
    w==powerdown_flag_clear_out) else $error("flags");
a_first_pair: assert property (t&&c==5 |=>
    w==($past(lq)==2'h2)) else $error("first");
a_second_pair: assert property (t&&c==6 |=>
    w==($past(lq)==2'h1)) else $error("second");
a_write_cause: assert property (mem_we_out |->
    $past(t&&(c==2||c==3))) else $error("cause");
a_call_noflag: assert property (t&&c==1 |=> !w)
    else $error("call flags");
a_clear_noflag: assert property (t&&(c==2||c==3) |=> !w)
    else $error("clear flags");
a_write_addr: assert property (t&&(c==2||c==3) |=>
    mem_waddr_out==$past(mem_addr_in)) else $error("addr");
a_push_cause: assert property (stack_push_out |->
    $past(t&&c==1)) else $error("push cause");
a_load_cause: assert property (pc_load_out |->
    $past(stack_push_out)) else $error("load cause");
a_stall_cause: assert property (!ready_out |->
    $past(t&&c==1)) else $error("stall cause");
endmodule
bind call_clear_exec call_clear_monitor mon (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .op_valid_in(op_valid_in),
    .op_code_in(op_code_in),
    .call_addr_in(call_addr_in),
    .mem_addr_in(mem_addr_in),
    .bit_sel_in(bit_sel_in),
    .mem_rdata_in(mem_rdata_in),
    .pc_in(pc_in),
    .ready_out(ready_out),
    .mem_we_out(mem_we_out),
    .mem_waddr_out(mem_waddr_out),
    .mem_wdata_out(mem_wdata_out),
    .stack_push_out(stack_push_out),
    .stack_data_out(stack_data_out),
    .pc_load_out(pc_load_out),
    .pc_next_out(pc_next_out),
    .watchdog_counter_clear_out(watchdog_counter_clear_out),
    .timeout_flag_clear_out(timeout_flag_clear_out),
    .powerdown_flag_clear_out(powerdown_flag_clear_out)
);
